/* hdl/lacd_top.sv */
// Command word decoder for a sixteen-line communications adapter, AXI4-Lite slave.
//
// What this block does
// - Bit 07 of an output character word selects normal (0) or transparent (1) sending.
// - Link codes 0-7: clear, RTS, not delete sync, sec RTS, hook, dial, EOT hunt, not loop.
// - Address bits 00 to 04 are zero whenever a line module 0 to F is addressed.
// - Inbound and outbound address words share one layout, line number in bits 05 to 08.
// - An input request word is handled without any line address.
// - The four-bit line number selects exactly one of sixteen line modules.
// - The off-hook line goes to the line access arrangement, not to the modem.
// - Data sent on the transmit line reach the far end as its receive data, and back; this block holds line_txd_o at mark and only synchronises line_rxd_i.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module lacd_top
    import lacd_pkg::*;
(
    input  wire logic               clock_i,        // 200 MHz system clock.
    input  wire logic               resetn_i,       // Asynchronous reset, active low.
    input  wire logic [AXI_AW-1:0]  s_axi_awaddr,   // Write address.
    input  wire logic               s_axi_awvalid,  // Write address valid.
    output logic                    s_axi_awready,  // Write address ready.
    input  wire logic [31:0]        s_axi_wdata,    // Write data.
    input  wire logic [3:0]         s_axi_wstrb,    // Write byte strobes.
    input  wire logic               s_axi_wvalid,   // Write data valid.
    output logic                    s_axi_wready,   // Write data ready.
    output logic [1:0]              s_axi_bresp,    // Write response.
    output logic                    s_axi_bvalid,   // Write response valid.
    input  wire logic               s_axi_bready,   // Write response ready.
    input  wire logic [AXI_AW-1:0]  s_axi_araddr,   // Read address.
    input  wire logic               s_axi_arvalid,  // Read address valid.
    output logic                    s_axi_arready,  // Read address ready.
    output logic [31:0]             s_axi_rdata,    // Read data.
    output logic [1:0]              s_axi_rresp,    // Read response.
    output logic                    s_axi_rvalid,   // Read data valid.
    input  wire logic               s_axi_rready,   // Read data ready.
    output logic [NLINES-1:0]       line_sel_o,     // One-hot target line, or all ones for an all-lines word, with a valid.
    output logic                    input_req_o,    // Input request pulse.
    output logic                    char_valid_o,   // Output character pulse.
    output logic [7:0]              char_data_o,    // Character data.
    output logic                    char_xpar_o,    // Character sent transparent.
    output logic                    char_dial_o,    // Character is a dial digit.
    output logic                    port_valid_o,   // Port command pulse.
    output logic [1:0]              port_return_o,  // Port return bits 06 and 07.
    output logic                    port_clear_o,   // Port clear.
    output logic                    resynchronize_port_port_o,  // Port resynchronize.
    output logic [NLINES-1:0]       rts_o,          // Request to send per line.
    output logic [NLINES-1:0]       sec_rts_o,      // Secondary request to send.
    output logic [NLINES-1:0]       not_del_sync_o, // Not delete sync mode.
    output logic [NLINES-1:0]       off_hook_daa_o, // Off hook to line access unit.
    output logic [NLINES-1:0]       dial_req_o,     // Dial request.
    output logic [NLINES-1:0]       eot_hunt_o,     // End of transmission hunt mode.
    output logic [NLINES-1:0]       not_loop_o,     // Not loop test.
    output logic [NLINES-1:0]       xpar_mode_o,    // Transparent text mode per line.
    output logic [NLINES-1:0]       line_txd_o,     // Transmitted data per line.
    input  wire logic [NLINES-1:0]  line_rxd_i      // Received data per line.
);
    logic                aw_have_q;
    logic [AXI_AW-1:0]   aw_addr_q;
    logic                w_have_q;
    logic [31:0]         w_data_q;
    logic [3:0]          w_strb_q;

    logic [15:0]         outadr_q;
    logic [15:0]         inadr_q;
    logic                ctrl_en_q;
    logic                adr_err_q;
    logic [NLINES-1:0]   rxd_meta_q;
    logic [NLINES-1:0]   rxd_q;
    logic [7:0]          lctl_q [NLINES];

    logic                fifo_in_valid;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic [31:0]         fifo_out_data;

    logic                wr_go;
    logic                wr_cmd;
    logic                wr_map;
    logic [15:0]         wr_val;
    logic [15:0]         cmd_w;
    logic [15:0]         adr_w;
    logic [1:0]          cmd_id;
    logic                adr_ok;
    logic [3:0]          line_no;
    logic [NLINES-1:0]   tgt;
    logic                fire;

    logic [31:0]         rd_val;
    logic                rd_map;

    // A write that pushes a command waits here while the FIFO is full, so the
    // response is held back and the master stalls instead of losing a word.
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign wr_cmd        = (aw_addr_q == REG_CMD_OFS);
    assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid && (!wr_cmd || fifo_in_ready);
    assign wr_map        = wr_cmd || (aw_addr_q == REG_OUTADR_OFS) ||
                           (aw_addr_q == REG_STAT_OFS) || (aw_addr_q == REG_CTRL_OFS);
    assign wr_val        = {w_strb_q[1] ? w_data_q[15:8] : 8'h00,
                            w_strb_q[0] ? w_data_q[7:0]  : 8'h00};
    assign fifo_in_valid = wr_go && wr_cmd;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q  <= 1'b0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[AXI_AW-1:2], 2'b00};
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            outadr_q  <= OUTADR_RST;
            ctrl_en_q <= CTRL_EN_RST;
        end else if (wr_go) begin
            if (aw_addr_q == REG_OUTADR_OFS) begin
                outadr_q <= wr_val;
            end
            if (aw_addr_q == REG_CTRL_OFS && w_strb_q[0]) begin
                ctrl_en_q <= w_data_q[0];
            end
        end
    end

    // Each command is stored with the address word current at its write.
    lacd_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({outadr_q, w_data_q[15:0]}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (ctrl_en_q),
        .out_data_o  (fifo_out_data)
    );

    assign fire    = fifo_out_valid && ctrl_en_q;
    assign cmd_w   = fifo_out_data[15:0];
    assign adr_w   = fifo_out_data[31:16];
    assign cmd_id  = cmd_w[B_ID_HI:B_ID_LO];
    assign adr_ok  = (adr_w[A_EXT_HI:A_EXT_LO] == 5'h00);
    // Address bits 09 to 15 are never looked at.
    assign line_no = adr_w[A_LINE_HI:A_LINE_LO];
    // An all-lines word reaches every module; otherwise a bad extended address reaches none.
    assign tgt     = cmd_w[B_BCAST] ? '1 :
                     (adr_ok ? (NLINES'(1) << line_no) : '0);

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            line_sel_o    <= '0;
            input_req_o   <= 1'b0;
            char_valid_o  <= 1'b0;
            char_data_o   <= '0;
            char_xpar_o   <= 1'b0;
            char_dial_o   <= 1'b0;
            port_valid_o  <= 1'b0;
            port_return_o <= '0;
            port_clear_o  <= 1'b0;
            resynchronize_port_port_o <= 1'b0;
        end else begin
            input_req_o  <= fire && cmd_id == ID_INREQ;
            char_valid_o <= fire && cmd_id == ID_CHAR;
            port_valid_o <= fire && cmd_id == ID_PORT;
            line_sel_o   <= (fire && cmd_id != ID_INREQ) ? tgt : '0;
            if (fire && cmd_id == ID_CHAR) begin
                char_data_o <= cmd_w[7:0];
                char_xpar_o <= cmd_w[B_XPAR];
                char_dial_o <= cmd_w[B_DIAL];
            end
            if (fire && cmd_id == ID_PORT) begin
                port_return_o <= {cmd_w[B_RET7], cmd_w[B_RET6]};
                port_clear_o  <= cmd_w[B_CLEAR];
                resynchronize_port_port_o <= cmd_w[B_RESYNCHRONIZE_PORT];
            end
        end
    end

    // Inbound address word mirrors the outbound layout for the last line addressed.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            inadr_q <= '0;
        end else if (fire && cmd_id != ID_INREQ && !cmd_w[B_BCAST] && adr_ok) begin
            inadr_q <= {5'h00, line_no, 7'h00};
        end
    end

    // Sticky error for a word whose extended address bits are not zero.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            adr_err_q <= 1'b0;
        end else if (fire && cmd_id != ID_INREQ && !cmd_w[B_BCAST] && !adr_ok) begin
            adr_err_q <= 1'b1;
        end else if (wr_go && aw_addr_q == REG_STAT_OFS && w_strb_q[0] && w_data_q[0]) begin
            adr_err_q <= 1'b0;
        end
    end

    // Link command state, one set per line module.
    for (genvar i = 0; i < NLINES; i++) begin : g_line
        always_ff @(posedge clock_i or negedge resetn_i) begin
            if (!resetn_i) begin
                lctl_q[i] <= '0;
            end else if (fire && cmd_id == ID_LINK && tgt[i]) begin
                if (cmd_w[B_CODE_HI:B_CODE_LO] == LK_MCLR) begin
                    if (cmd_w[B_SETCMD]) begin
                        lctl_q[i] <= '0;
                    end
                end else begin
                    lctl_q[i][cmd_w[B_CODE_HI:B_CODE_LO]] <= cmd_w[B_SETCMD];
                end
                lctl_q[i][0] <= cmd_w[B_XPEN];
            end
        end
        assign rts_o[i]          = lctl_q[i][LK_RTS];
        assign not_del_sync_o[i] = lctl_q[i][LK_NDSYNC];
        assign sec_rts_o[i]      = lctl_q[i][LK_SRTS];
        assign off_hook_daa_o[i] = lctl_q[i][LK_HOOK];
        assign dial_req_o[i]     = lctl_q[i][LK_DIAL];
        assign eot_hunt_o[i]     = lctl_q[i][LK_EOT];
        assign not_loop_o[i]     = lctl_q[i][LK_NLOOP];
        // Code 0 never stores a level, so its slot holds the transparent mode bit.
        assign xpar_mode_o[i]    = lctl_q[i][0];
    end

    // Serial data are carried by the line modules; here the transmit lines idle
    // at mark and the receive lines are synchronised for software to watch.
    assign line_txd_o = '1;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rxd_meta_q <= '1;
            rxd_q      <= '1;
        end else begin
            rxd_meta_q <= line_rxd_i;
            rxd_q      <= rxd_meta_q;
        end
    end

    always_comb begin
        rd_map = 1'b1;
        rd_val = '0;
        unique case ({s_axi_araddr[AXI_AW-1:2], 2'b00})
            REG_INADR_OFS: rd_val = {16'h0000, inadr_q};
            REG_STAT_OFS:  rd_val = {29'h0, fifo_out_valid, !fifo_in_ready, adr_err_q};
            REG_CTRL_OFS:  rd_val = {31'h0, ctrl_en_q};
            REG_RXD_OFS:   rd_val = {16'h0000, rxd_q};
            REG_XPAR_OFS:  rd_val = {16'h0000, xpar_mode_o};
            REG_CMD_OFS,
            REG_OUTADR_OFS: rd_val = '0;
            default:       rd_map = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : lacd_top

/* hdl/lacd_pkg.sv */
// Constants shared by the line adapter command decoder and its bench.
package lacd_pkg;
    // Register byte offsets.
    localparam logic [7:0] REG_CMD_OFS    = 8'h00;
    localparam logic [7:0] REG_OUTADR_OFS = 8'h04;
    localparam logic [7:0] REG_INADR_OFS  = 8'h08;
    localparam logic [7:0] REG_STAT_OFS   = 8'h0c;
    localparam logic [7:0] REG_CTRL_OFS   = 8'h10;
    localparam logic [7:0] REG_RXD_OFS    = 8'h14;
    localparam logic [7:0] REG_XPAR_OFS   = 8'h18;
    localparam int         AXI_AW         = 8;
    // Reset values.
    localparam logic [15:0] OUTADR_RST    = 16'h0000;
    localparam logic        CTRL_EN_RST   = 1'b1;
    // Bit positions in a 16-bit word; printed bit n sits at word bit 15-n.
    localparam int B_BCAST   = 15;
    localparam int B_ID_HI   = 14;
    localparam int B_ID_LO   = 13;
    localparam int B_DIAL    = 9;
    localparam int B_XPAR    = 8;
    localparam int B_RET6    = 9;
    localparam int B_RET7    = 8;
    localparam int B_CLEAR   = 7;
    localparam int B_RESYNCHRONIZE_PORT  = 4;
    localparam int B_XPEN    = 4;
    localparam int B_CODE_HI = 3;
    localparam int B_CODE_LO = 1;
    localparam int B_SETCMD  = 0;
    localparam int A_EXT_HI  = 15;
    localparam int A_EXT_LO  = 11;
    localparam int A_LINE_HI = 10;
    localparam int A_LINE_LO = 7;
    // Command identifiers.
    localparam logic [1:0] ID_INREQ = 2'b00;
    localparam logic [1:0] ID_CHAR  = 2'b01;
    localparam logic [1:0] ID_PORT  = 2'b10;
    localparam logic [1:0] ID_LINK  = 2'b11;
    // Link command codes.
    localparam logic [2:0] LK_MCLR   = 3'h0;
    localparam logic [2:0] LK_RTS    = 3'h1;
    localparam logic [2:0] LK_NDSYNC = 3'h2;
    localparam logic [2:0] LK_SRTS   = 3'h3;
    localparam logic [2:0] LK_HOOK   = 3'h4;
    localparam logic [2:0] LK_DIAL   = 3'h5;
    localparam logic [2:0] LK_EOT    = 3'h6;
    localparam logic [2:0] LK_NLOOP  = 3'h7;
    localparam int NLINES     = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 32;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : lacd_pkg

/* hdl/lacd_fifo.sv */
// Command FIFO with registered read data.
`timescale 1ns/1ps
module lacd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clock_i,    // System clock.
    input  wire logic             resetn_i,   // Asynchronous reset, active low.
    input  wire logic             in_valid_i, // Write side valid.
    output logic                  in_ready_o, // Write side ready, low when full.
    input  wire logic [WIDTH-1:0] in_data_i,  // Write side data.
    output logic                  out_valid_o, // Read side valid.
    input  wire logic             out_ready_i, // Read side ready.
    output logic      [WIDTH-1:0] out_data_o  // Read side data, registered.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign in_ready_o = (count_q != (AW+1)'(DEPTH));
    assign push       = in_valid_i && in_ready_o;
    // The output register refills whenever it is empty or being taken.
    assign pop        = (count_q != '0) && (!out_valid_o || out_ready_i);

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (pop) begin
            out_valid_o <= 1'b1;
            out_data_o  <= mem_q[rptr_q];
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end
endmodule : lacd_fifo

/* tb/lacd_top_props.sv */
// Concurrent checks on the ports of the line adapter command decoder.
`timescale 1ns/1ps
module lacd_top_props
    import lacd_pkg::*;
(
    input wire logic              clock_i,        // System clock.
    input wire logic              resetn_i,       // Reset, active low.
    input wire logic              s_axi_bvalid,   // Write response valid.
    input wire logic              s_axi_bready,   // Write response ready.
    input wire logic [1:0]        s_axi_bresp,    // Write response.
    input wire logic              s_axi_arvalid,  // Read address valid.
    input wire logic              s_axi_arready,  // Read address ready.
    input wire logic              s_axi_rvalid,   // Read data valid.
    input wire logic              s_axi_rready,   // Read data ready.
    input wire logic [31:0]       s_axi_rdata,    // Read data.
    input wire logic [NLINES-1:0] line_sel_o,     // Target lines.
    input wire logic              input_req_o,    // Input request pulse.
    input wire logic              char_valid_o,   // Character pulse.
    input wire logic [7:0]        char_data_o,    // Character data.
    input wire logic              char_xpar_o,    // Transparent flag.
    input wire logic              port_valid_o,   // Port command pulse.
    input wire logic [NLINES-1:0] off_hook_daa_o, // Off hook per line.
    input wire logic [NLINES-1:0] line_txd_o      // Transmit data per line.
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    inreq_no_line_a: assert property (input_req_o |-> line_sel_o == '0)
        else $error("Line on input request.");
    sel_one_line_a: assert property (line_sel_o != '0 |->
        ($onehot(line_sel_o) || &line_sel_o))
        else $error("Bad line selection.");
    kind_exclusive_a: assert property ($onehot0({input_req_o, char_valid_o, port_valid_o}))
        else $error("Two kinds at once.");
    char_hold_a: assert property (!char_valid_o |-> $stable(char_data_o))
        else $error("Character moved.");
    xpar_hold_a: assert property (!char_valid_o |-> $stable(char_xpar_o))
        else $error("Flag moved.");
    hook_target_a: assert property ($changed(off_hook_daa_o) |->
        ((off_hook_daa_o ^ $past(off_hook_daa_o)) & ~line_sel_o) == '0)
        else $error("Stray hook change.");
    txd_mark_a: assert property (line_txd_o == '1)
        else $error("Transmit not at mark.");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Response dropped.");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("No read data.");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data moved.");

    inreq_c: cover property (input_req_o);
    xpar_char_c: cover property (char_valid_o && char_xpar_o);
    hook_c: cover property (off_hook_daa_o != '0);
endmodule : lacd_top_props

/* tb/lacd_line_model.sv */
// Line-side stand-in for the modems on all sixteen lines.
`timescale 1ns/1ps
module lacd_line_model
    import lacd_pkg::*;
(
    input  wire logic [NLINES-1:0] line_txd_i, // Adapter transmit data.
    input  wire logic              loop_i,     // Loop transmit back to receive.
    input  wire logic [NLINES-1:0] pattern_i,  // Receive level when not looped.
    output logic      [NLINES-1:0] line_rxd_o  // Adapter receive data.
);
    // Looped, what the adapter sends comes straight back as its received data.
    assign line_rxd_o = loop_i ? line_txd_i : pattern_i;
endmodule : lacd_line_model

/* tb/lacd_top_tb.sv */
// Self-checking bench for the line adapter command decoder.
`timescale 1ns/1ps
module lacd_top_tb;
    import lacd_pkg::*;
    logic              clock_i = 1'h0, resetn_i = 1'h0, loop_mode = 1'h0;
    logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0]       s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp, port_return_o, rsp;
    logic              input_req_o, char_valid_o, char_xpar_o, char_dial_o, port_valid_o;
    logic              port_clear_o, resynchronize_port_port_o;
    logic [7:0]        char_data_o;
    logic [NLINES-1:0] line_sel_o, rts_o, sec_rts_o, not_del_sync_o, off_hook_daa_o, dial_req_o;
    logic [NLINES-1:0] eot_hunt_o, not_loop_o, xpar_mode_o, line_txd_o, line_rxd_i, last_sel;
    logic [NLINES-1:0] rx_pattern = 16'h5a3c;
    logic [2:0]        last_kind;
    int                mismatches = 0, comparisons = 0, npulse = 0, ninreq = 0, n, c;

    always #2.5 clock_i = ~clock_i;

    lacd_top dut_u (.*);
    lacd_line_model line_u (.line_txd_i(line_txd_o), .loop_i(loop_mode),
        .pattern_i(rx_pattern), .line_rxd_o(line_rxd_i));

    // Sampled mid-cycle, clear of the decoder's own edge.
    always @(negedge clock_i) begin
        if (line_sel_o !== 16'h0 || input_req_o === 1'h1) begin
            npulse++;
            last_sel = line_sel_o;
            last_kind = {input_req_o, char_valid_o, port_valid_o};
        end
        if (input_req_o === 1'h1) ninreq++;
    end

    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : chk

    task timed_out(input string what);
        mismatches++;
        $display("CHECK FAILED at %0t: %s never answered", $time, what);
        give_verdict;
    endtask : timed_out

    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clock_i);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        for (int k = 0; k < 200; k++) begin
            @(negedge clock_i);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r  = s_axi_bresp;
            @(posedge clock_i);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (tb) begin
                s_axi_bready <= 1'h0;
                return;
            end
        end
        timed_out("write");
    endtask : axi_wr

    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clock_i);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        for (int k = 0; k < 200; k++) begin
            @(negedge clock_i);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d  = s_axi_rdata;
            r  = s_axi_rresp;
            @(posedge clock_i);
            if (ta) s_axi_arvalid <= 1'h0;
            if (tr) begin
                s_axi_rready <= 1'h0;
                return;
            end
        end
        timed_out("read");
    endtask : axi_rd

    // One command word, then wait for its decode.
    task cmd(input logic [15:0] w);
        n = npulse;
        axi_wr(REG_CMD_OFS, {16'h0, w}, rsp);
        for (int k = 0; k < 20; k++) begin
            @(posedge clock_i);
            if (npulse != n) return;
        end
        timed_out("decode");
    endtask : cmd

    function automatic logic [NLINES-1:0] level(input int code);
        case (code)
            1: return rts_o;
            2: return not_del_sync_o;
            3: return sec_rts_o;
            4: return off_hook_daa_o;
            5: return dial_req_o;
            6: return eot_hunt_o;
            default: return not_loop_o;
        endcase
    endfunction : level

    initial begin
        repeat (6) @(posedge clock_i);
        resetn_i <= 1'h1;
        axi_rd(REG_CTRL_OFS, rd, rsp);
        chk(rd & 32'h1, 32'(CTRL_EN_RST), "enable");
        axi_rd(8'h1c, rd, rsp);
        chk(rd, 32'h0, "unmapped");
        chk(32'(rsp), 32'(RESP_SLVERR), "unmapped");
        axi_wr(REG_INADR_OFS, 32'h0, rsp);
        chk(32'(rsp), 32'(RESP_SLVERR), "ro write");
        axi_rd(REG_RXD_OFS, rd, rsp);
        chk(rd, 32'h5a3c, "rxd");
        loop_mode <= 1'h1;
        repeat (2) @(posedge clock_i);
        axi_rd(REG_RXD_OFS, rd, rsp);
        chk(rd, 32'hffff, "loop");
        for (c = 1; c < 8; c++) begin
            axi_wr(REG_OUTADR_OFS, 32'(c * 2) << 7, rsp);
            cmd(16'h6011 | 16'(c << 1));
            chk(32'(last_sel), 32'h1 << (c * 2), "sel");
            chk(32'(level(c)), 32'h1 << (c * 2), "set");
            chk(32'(xpar_mode_o), 32'h1 << (c * 2), "xpar");
            cmd(16'h6000 | 16'(c << 1));
            chk(32'(level(c)), 32'h0, "reset");
        end
        axi_wr(REG_OUTADR_OFS, 32'h0180, rsp);
        cmd(16'h6009);
        cmd(16'h6001);
        chk(32'(off_hook_daa_o), 32'h0, "clear");
        axi_wr(REG_OUTADR_OFS, 32'h029f, rsp);
        cmd(16'h23a5);
        chk({last_sel, 6'h0, char_dial_o, char_xpar_o, char_data_o},
            {16'h0020, 8'h03, 8'ha5}, "char");
        cmd(16'h20c3);
        chk({22'h0, char_dial_o, char_xpar_o, char_data_o}, 32'h00c3, "char");
        axi_rd(REG_INADR_OFS, rd, rsp);
        chk(rd, 32'h0280, "inadr");
        axi_wr(REG_OUTADR_OFS, 32'h0a80, rsp);
        n = npulse;
        axi_wr(REG_CMD_OFS, 32'h6009, rsp);
        repeat (8) @(posedge clock_i);
        chk(32'(npulse - n), 32'h0, "ext adr");
        axi_rd(REG_STAT_OFS, rd, rsp);
        chk(rd & 32'h1, 32'h1, "adr err");
        cmd(16'h0000);
        chk({13'h0, last_kind, last_sel}, {13'h0, 3'h4, 16'h0000}, "inreq");
        axi_wr(REG_OUTADR_OFS, 32'h0080, rsp);
        cmd(16'h4390);
        chk({9'h0, last_kind, port_return_o, port_clear_o, resynchronize_port_port_o, last_sel},
            {9'h0, 3'h1, 4'hf, 16'h0002}, "port");
        axi_wr(REG_CTRL_OFS, 32'h0, rsp);
        repeat (17) axi_wr(REG_CMD_OFS, 32'h0, rsp);
        axi_rd(REG_STAT_OFS, rd, rsp);
        chk(rd & 32'h6, 32'h6, "full");
        n = ninreq;
        axi_wr(REG_CTRL_OFS, 32'h1, rsp);
        repeat (40) @(posedge clock_i);
        chk(32'(ninreq - n), 32'h11, "queued");
        give_verdict;
    end
endmodule : lacd_top_tb

bind lacd_top lacd_top_props props_u (.clock_i, .resetn_i, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .line_sel_o, .input_req_o, .char_valid_o, .char_data_o, .char_xpar_o, .port_valid_o,
    .off_hook_daa_o, .line_txd_o);
